// ### core/serial_port_params.svh
// Offsets, field positions, reset values and frame counts of the serial register port
`ifndef SERIAL_PORT_PARAMS_SVH
`define SERIAL_PORT_PARAMS_SVH

`define REG_COUNT 16
`define REG_WIDTH 8
`define REG_RESET 8'h00

`define OFS_STATUS_FLAGS 4'h0
`define OFS_HEAD_RETRACT_A 4'h1
`define OFS_HEAD_RETRACT_B 4'h2
`define OFS_MOTOR_STATE 4'h3
`define OFS_SPINDLE_DRIVE 4'h4
`define OFS_PROTOCOL_CTRL 4'h5
`define OFS_WAVEFORM 4'h6
`define OFS_COMMUTATION 4'h7
`define OFS_SPINDLE_AMPL 4'h8
`define OFS_COIL_CMD_HIGH 4'h9
`define OFS_COIL_CMD_LOW 4'ha
`define OFS_CONV_RESULT_HIGH 4'hb
`define OFS_CONV_RESULT_LOW 4'hc
`define OFS_RESERVED_D 4'hd
`define OFS_RESERVED_E 4'he
`define OFS_FACTORY_TEST 4'hf

// Field positions
`define PROTOCOL_SELECT_POS 7
`define STATUS_REV_MSB 2
`define CONV_LOW_RW_MSB 5

// Frame layout, in sampled bits
`define FRAME_BITS 5'h10
`define FRAME_HEAD_BITS 5'h08
`define FRAME_COUNT_MAX 5'h11

`endif

// ### core/serial_port_pkg.sv
// Types shared by the serial register port modules
package serial_port_pkg;
  typedef logic [3:0] reg_addr_t;
  typedef logic [7:0] reg_byte_t;
  typedef logic [4:0] edge_count_t;
  typedef logic [2:0] device_select_t;
  typedef logic [15:0][7:0] reg_image_t;
  typedef enum logic {FRAME_WRITE, FRAME_READ} frame_kind_t;
endpackage

// ### core/bank_carrier_if.sv
// Carrier between the link-side frame logic and the register bank
`timescale 1ns/1ps
interface bank_carrier_if;
  // Committed write, held steady while the toggle crosses
  logic wr_toggle;
  serial_port_pkg::reg_addr_t wr_addr;
  serial_port_pkg::reg_byte_t wr_data;
  // Read view of all sixteen registers
  serial_port_pkg::reg_image_t read_image;

  modport link (
    output wr_toggle,
    output wr_addr,
    output wr_data,
    input read_image
  );
  modport bank (
    input wr_toggle,
    input wr_addr,
    input wr_data,
    output read_image
  );
endinterface

// ### core/register_bank.sv
// Sixteen 8-bit registers on the system clock, written from committed serial frames
`timescale 1ns/1ps
`include "serial_port_params.svh"
module register_bank #(
  parameter logic [2:0] REVISION = 3'h1
) (
  // System clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Link-side carrier
  bank_carrier_if.bank carrier,
  // Asynchronous status sources
  input wire logic thermal_warning_flag,
  input wire logic thermal_shutdown_flag,
  input wire logic speed_sync_fault_flag,
  input wire logic cal_compare_flag,
  input wire logic spindle_current_sign,
  input wire logic [9:0] converter_data,
  // Register contents
  output logic [127:0] register_image
);
  serial_port_pkg::reg_byte_t regs_q [`REG_COUNT];
  logic [2:0] tog_q;
  logic [14:0] ext_meta_q;
  logic [14:0] ext_q;
  logic wr_event;
  logic read_only_hit;
  serial_port_pkg::reg_byte_t status_value;

  // Status and converter pins pass two flip-flops before use
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ext_meta_q <= 15'h0000;
      ext_q <= 15'h0000;
    end else begin
      ext_meta_q <= {spindle_current_sign, cal_compare_flag, speed_sync_fault_flag,
                     thermal_shutdown_flag, thermal_warning_flag, converter_data};
      ext_q <= ext_meta_q;
    end
  end

  // Write toggle crosses by two flip-flops, the third gives the edge
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tog_q <= 3'h0;
    end else begin
      tog_q <= {tog_q[1:0], carrier.wr_toggle};
    end
  end

  assign wr_event = tog_q[2] ^ tog_q[1];
  // Status and converter-high slots are read-only and keep their stored zero
  assign read_only_hit = (carrier.wr_addr == `OFS_STATUS_FLAGS) || (carrier.wr_addr == `OFS_CONV_RESULT_HIGH);
  assign status_value = {ext_q[14:10], REVISION};

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `REG_COUNT; i++) begin
        regs_q[i] <= `REG_RESET;
      end
    end else if (wr_event && !read_only_hit) begin
      regs_q[carrier.wr_addr] <= carrier.wr_data;
    end
  end

  always_comb begin
    for (int i = 0; i < `REG_COUNT; i++) begin
      carrier.read_image[i] = regs_q[i];
    end
    carrier.read_image[`OFS_STATUS_FLAGS] = status_value;
    carrier.read_image[`OFS_CONV_RESULT_HIGH] = ext_q[9:2];
    carrier.read_image[`OFS_CONV_RESULT_LOW] = {ext_q[1:0], regs_q[`OFS_CONV_RESULT_LOW][`CONV_LOW_RW_MSB:0]};
  end

  always_comb begin
    for (int i = 0; i < `REG_COUNT; i++) begin
      register_image[i*8 +: 8] = regs_q[i];
    end
  end
endmodule

// ### core/serial_register_port.sv
// Three-wire serial register port with default and inverted-clock framing
//
// Behaviour
// - Inverted mode: first rising edge samples R/W
// - Low clock at enable fall: next rise counts
// - Write commits only after exactly sixteen edges
// - First bit low writes, high reads
// - Identifier, address, data sampled on successive edges
// - Eighth sampling edge takes last address bit
// - Device drives line at next opposite edge
// - Read data advances on each sampling edge
// - Frame identifier must match device identifier
// - Sixteen eight-bit registers chosen by address
// - All stored register bits zero after reset; status flag bits and converter bits read live inputs, status bits 2..0 give REVISION
// - Default mode samples on falling edges
`timescale 1ns/1ps
`include "serial_port_params.svh"
module serial_register_port #(
  parameter logic [2:0] DEVICE_SELECT = 3'h5,
  parameter logic [2:0] REVISION = 3'h1
) (
  // System clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Serial link, clocked by the host
  input wire logic serial_clock,
  input wire logic serial_enable_line,
  input wire logic serial_io_in,
  output logic serial_io_out,
  output logic serial_io_oe_n,
  // Status sources
  input wire logic thermal_warning_flag,
  input wire logic thermal_shutdown_flag,
  input wire logic speed_sync_fault_flag,
  input wire logic cal_compare_flag,
  input wire logic spindle_current_sign,
  input wire logic [9:0] converter_data,
  // Register contents and active protocol
  output logic [127:0] register_image,
  output logic protocol_select_bit
);
  // DEVICE_SELECT and REVISION defaults are arbitrary

  bank_carrier_if carrier ();

  // Rising-edge sampler (inverted-clock mode)
  serial_port_pkg::edge_count_t rise_cnt_q;
  logic [15:0] rise_sh_q;
  serial_port_pkg::reg_byte_t rise_out_q;
  // Falling-edge sampler (default mode)
  serial_port_pkg::edge_count_t fall_cnt_q;
  logic [15:0] fall_sh_q;
  serial_port_pkg::reg_byte_t fall_out_q;
  // Turnaround flags, set on the edge opposite to sampling
  logic rise_mode_drive_q;
  logic fall_mode_drive_q;
  // Frame-end state, clocked by the enable rising edge; proto_sync_q is on the system clock
  logic protocol_q;
  logic wr_toggle_q;
  serial_port_pkg::reg_addr_t wr_addr_q;
  serial_port_pkg::reg_byte_t wr_data_q;
  logic [1:0] proto_sync_q;

  logic frame_idle;
  logic [15:0] frame_sh;
  serial_port_pkg::edge_count_t frame_cnt;
  logic frame_write_ok;
  serial_port_pkg::reg_addr_t frame_addr;
  serial_port_pkg::reg_byte_t frame_data;
  serial_port_pkg::reg_addr_t rise_rd_addr;
  serial_port_pkg::reg_addr_t fall_rd_addr;
  logic rise_drive_now;
  logic fall_drive_now;

  function automatic serial_port_pkg::edge_count_t count_up(input serial_port_pkg::edge_count_t c);
    // Saturates so that a seventeenth edge never wraps back to sixteen
    count_up = (c == `FRAME_COUNT_MAX) ? c : c + 5'h01;
  endfunction

  // Head is complete: R/W then identifier sit in bits 7..4 after eight samples
  function automatic logic read_head_ok(input serial_port_pkg::edge_count_t c, input logic [15:0] sh);
    read_head_ok = (c == `FRAME_HEAD_BITS) &&
                   (serial_port_pkg::frame_kind_t'(sh[7]) == serial_port_pkg::FRAME_READ) &&
                   (sh[6:4] == DEVICE_SELECT);
  endfunction

  assign frame_idle = serial_enable_line;
  // Address of a read: three bits already in, the fourth on the wire
  assign rise_rd_addr = {rise_sh_q[2:0], serial_io_in};
  assign fall_rd_addr = {fall_sh_q[2:0], serial_io_in};
  assign rise_drive_now = read_head_ok(rise_cnt_q, rise_sh_q);
  assign fall_drive_now = read_head_ok(fall_cnt_q, fall_sh_q);

  // sampling on serial clock rising edges
  // counter cleared while enabled high, so any first rise counts
  always_ff @(posedge serial_clock or posedge frame_idle) begin
    if (frame_idle) begin
      rise_cnt_q <= 5'h00;
      rise_sh_q <= 16'h0000;
    end else begin
      rise_cnt_q <= count_up(rise_cnt_q);
      rise_sh_q <= {rise_sh_q[14:0], serial_io_in};
    end
  end

  // sampling on serial clock falling edges
  always_ff @(negedge serial_clock or posedge frame_idle) begin
    if (frame_idle) begin
      fall_cnt_q <= 5'h00;
      fall_sh_q <= 16'h0000;
    end else begin
      fall_cnt_q <= count_up(fall_cnt_q);
      fall_sh_q <= {fall_sh_q[14:0], serial_io_in};
    end
  end

  // eighth rise loads read byte, later rises shift it
  // data advances on each rising edge
  always_ff @(posedge serial_clock or posedge frame_idle) begin
    if (frame_idle) begin
      rise_out_q <= 8'h00;
    end else if (rise_cnt_q == `FRAME_HEAD_BITS - 5'h01) begin
      rise_out_q <= carrier.read_image[rise_rd_addr];
    end else begin
      rise_out_q <= {rise_out_q[6:0], 1'b0};
    end
  end

  always_ff @(negedge serial_clock or posedge frame_idle) begin
    if (frame_idle) begin
      fall_out_q <= 8'h00;
    end else if (fall_cnt_q == `FRAME_HEAD_BITS - 5'h01) begin
      fall_out_q <= carrier.read_image[fall_rd_addr];
    end else begin
      fall_out_q <= {fall_out_q[6:0], 1'b0};
    end
  end

  // take the line on the first opposite edge after the head
  // released as soon as enable rises
  always_ff @(negedge serial_clock or posedge frame_idle) begin
    if (frame_idle) begin
      rise_mode_drive_q <= 1'b0;
    end else if (rise_drive_now) begin
      rise_mode_drive_q <= 1'b1;
    end
  end

  always_ff @(posedge serial_clock or posedge frame_idle) begin
    if (frame_idle) begin
      fall_mode_drive_q <= 1'b0;
    end else if (fall_drive_now) begin
      fall_mode_drive_q <= 1'b1;
    end
  end

  // The active protocol picks one sampler; the other runs unused
  assign frame_sh = protocol_q ? rise_sh_q : fall_sh_q;
  assign frame_cnt = protocol_q ? rise_cnt_q : fall_cnt_q;
  assign frame_addr = frame_sh[11:8];
  assign frame_data = frame_sh[7:0];
  assign frame_write_ok = (frame_cnt == `FRAME_BITS) &&
                          (serial_port_pkg::frame_kind_t'(frame_sh[15]) == serial_port_pkg::FRAME_WRITE) &&
                          (frame_sh[14:12] == DEVICE_SELECT);

  // Commit at frame end; enable rising sees the counters before their clear
  // shorter frames leave every register untouched
  // protocol changes only take effect from the next frame
  always_ff @(posedge serial_enable_line or negedge arst_n) begin
    if (!arst_n) begin
      protocol_q <= 1'b0;
      wr_toggle_q <= 1'b0;
      wr_addr_q <= 4'h0;
      wr_data_q <= 8'h00;
    end else if (frame_write_ok) begin
      wr_toggle_q <= ~wr_toggle_q;
      wr_addr_q <= frame_addr;
      wr_data_q <= frame_data;
      if (frame_addr == `OFS_PROTOCOL_CTRL) begin
        protocol_q <= frame_data[`PROTOCOL_SELECT_POS];
      end
    end
  end

  // Address and data stay put until the next frame, long after the toggle lands
  assign carrier.wr_toggle = wr_toggle_q;
  assign carrier.wr_addr = wr_addr_q;
  assign carrier.wr_data = wr_data_q;

  // Protocol level brought onto the system clock for the status output
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      proto_sync_q <= 2'h0;
    end else begin
      proto_sync_q <= {proto_sync_q[0], protocol_q};
    end
  end

  assign protocol_select_bit = proto_sync_q[1];

  // Pin is a flip-flop chosen by a mode that is steady for the whole frame
  // most significant bit first
  assign serial_io_out = protocol_q ? rise_out_q[7] : fall_out_q[7];
  assign serial_io_oe_n = protocol_q ? ~rise_mode_drive_q : ~fall_mode_drive_q;

  register_bank #(
    .REVISION(REVISION)
  ) bank_i (
    .clock(clock),
    .arst_n(arst_n),
    .carrier(carrier.bank),
    .thermal_warning_flag(thermal_warning_flag),
    .thermal_shutdown_flag(thermal_shutdown_flag),
    .speed_sync_fault_flag(speed_sync_fault_flag),
    .cal_compare_flag(cal_compare_flag),
    .spindle_current_sign(spindle_current_sign),
    .converter_data(converter_data),
    .register_image(register_image)
  );
endmodule

// ### verif/serial_port_props.sv
// Concurrent checks on the serial register port pins
`timescale 1ns/1ps
module serial_port_props (
  // Clocks and reset
  input wire logic clock,
  input wire logic arst_n,
  input wire logic serial_clock,
  // Link
  input wire logic serial_enable_line,
  input wire logic serial_io_out,
  input wire logic serial_io_oe_n,
  // Contents
  input wire logic [127:0] register_image,
  input wire logic protocol_select_bit
);
  logic [4:0] rise_q;
  logic [4:0] fall_q;
  logic out_r_q;
  logic oe_r_q;
  logic out_f_q;
  logic oe_f_q;
  // Edge counts restart with every frame
  always_ff @(posedge serial_clock or posedge serial_enable_line) begin
    if (serial_enable_line) rise_q <= 5'h00;
    else if (rise_q != 5'h1f) rise_q <= rise_q + 5'h01;
  end
  always_ff @(negedge serial_clock or posedge serial_enable_line) begin
    if (serial_enable_line) fall_q <= 5'h00;
    else if (fall_q != 5'h1f) fall_q <= fall_q + 5'h01;
  end
  always_ff @(posedge serial_clock) begin
    out_r_q <= serial_io_out;
    oe_r_q <= serial_io_oe_n;
  end
  always_ff @(negedge serial_clock) begin
    out_f_q <= serial_io_out;
    oe_f_q <= serial_io_oe_n;
  end
  sequence idle_s;
    serial_enable_line [*2];
  endsequence
  a_idle_release: assert property (
    @(posedge clock) disable iff (!arst_n) idle_s |-> serial_io_oe_n) else $error("line driven when idle");
  a_commit_idle: assert property (
    @(posedge clock) disable iff (!arst_n) $changed(register_image)
    |-> $past(serial_enable_line) && $past(serial_enable_line, 2)) else $error("write inside frame");
  a_mode_follow: assert property (
    @(posedge clock) disable iff (!arst_n) register_image[47] != protocol_select_bit
    |-> ##[1:3] register_image[47] == protocol_select_bit) else $error("protocol not updated");
  a_ro_zero: assert property (
    @(posedge clock) disable iff (!arst_n) register_image[7:0] == 8'h00 && register_image[95:88] == 8'h00)
    else $error("read-only byte stored");
  a_reset_clear: assert property (
    @(posedge clock) disable iff (!arst_n) $rose(arst_n) |-> register_image == 128'h0 && !protocol_select_bit)
    else $error("not clear after reset");
  a_turn_inv: assert property (
    @(negedge serial_clock) disable iff (serial_enable_line) protocol_select_bit && $fell(serial_io_oe_n)
    |-> rise_q == 5'h09) else $error("inverted turnaround misplaced");
  a_turn_def: assert property (
    @(posedge serial_clock) disable iff (serial_enable_line) !protocol_select_bit && $fell(serial_io_oe_n)
    |-> fall_q == 5'h09) else $error("default turnaround misplaced");
  a_hold_inv: assert property (
    @(posedge serial_clock) disable iff (serial_enable_line) protocol_select_bit && !oe_f_q && !serial_io_oe_n
    |-> serial_io_out == out_f_q) else $error("data moved on fall");
  a_hold_def: assert property (
    @(negedge serial_clock) disable iff (serial_enable_line) !protocol_select_bit && !oe_r_q && !serial_io_oe_n
    |-> serial_io_out == out_r_q) else $error("data moved on rise");
endmodule
bind serial_register_port serial_port_props i_props (.clock(clock), .arst_n(arst_n), .serial_clock(serial_clock),
  .serial_enable_line(serial_enable_line), .serial_io_out(serial_io_out), .serial_io_oe_n(serial_io_oe_n),
  .register_image(register_image), .protocol_select_bit(protocol_select_bit));

// ### verif/serial_host_model.sv
// Host controller model on the three-wire link
`timescale 1ns/1ps
module serial_host_model (
  // Link driven by the host
  output logic serial_clock,
  output logic serial_enable_line,
  output logic serial_io_in,
  // Device side of the data pin
  input wire logic serial_io_out,
  input wire logic serial_io_oe_n
);
  logic hd;
  logic hd_en;
  // Released line falls to the pull-down level
  assign serial_io_in = !serial_io_oe_n ? serial_io_out : (hd_en ? hd : 1'b0);
  initial begin
    serial_clock = 1'b0;
    serial_enable_line = 1'b0;
    hd = 1'b0;
    hd_en = 1'b1;
    // A clean rising enable clears the link-side flops, which start unknown
    #1 serial_enable_line = 1'b1;
  end
  task automatic frame(input bit inv, input logic [16:0] bits, input int n, output logic [7:0] rd, output bit drove);
    drove = 1'b0;
    rd = 8'h00;
    hd_en = 1'b1;
    serial_enable_line = 1'b0;
    #15;
    for (int i = 0; i < n; i++) begin
      hd = bits[16 - i];
      #2;
      if (inv && i > 7) rd = {rd[6:0], serial_io_in};
      #1 serial_clock = 1'b1;
      #1;
      if (inv && i == 7 && bits[16]) hd_en = 1'b0;
      #4;
      if (!inv && i > 7) rd = {rd[6:0], serial_io_in};
      #1 serial_clock = 1'b0;
      #3;
      if (!inv && i == 7 && bits[16]) hd_en = 1'b0;
      drove = drove | !serial_io_oe_n;
    end
    // Enable stays low long enough for the minimum frame time
    #300 serial_enable_line = 1'b1;
    #20;
  endtask
endmodule

// ### verif/tb_top.sv
// Self-checking bench for the serial register port
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [3:0] a; logic [7:0] w; logic [7:0] img; logic [7:0] rd;} row_t;
  // Arbitrary identifier value
  localparam logic [2:0] dev_id = 3'h5;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] flags = 5'b10110;
  logic [9:0] conv = 10'h2a5;
  wire serial_clock, serial_enable_line, serial_io_in, serial_io_out, serial_io_oe_n, protocol_select_bit;
  wire [127:0] register_image;
  logic [127:0] model = 128'h0;
  logic [7:0] rd_v;
  bit drv;
  int error_cnt = 0;
  int checks = 0;
  row_t rows [8] = '{'{4'h1, 8'h5a, 8'h5a, 8'h5a}, '{4'h2, 8'ha5, 8'ha5, 8'ha5}, '{4'h9, 8'h81, 8'h81, 8'h81},
    '{4'hd, 8'h7e, 8'h7e, 8'h7e}, '{4'hf, 8'h3c, 8'h3c, 8'h3c}, '{4'h0, 8'hff, 8'h00, 8'hb1},
    '{4'hb, 8'hff, 8'h00, 8'ha9}, '{4'hc, 8'hff, 8'hff, 8'h7f}};
  always #20 clock = ~clock;
  serial_register_port #(.DEVICE_SELECT(dev_id), .REVISION(3'h1)) i_dut (.clock(clock), .arst_n(arst_n),
    .serial_clock(serial_clock), .serial_enable_line(serial_enable_line), .serial_io_in(serial_io_in),
    .serial_io_out(serial_io_out), .serial_io_oe_n(serial_io_oe_n), .thermal_warning_flag(flags[0]),
    .thermal_shutdown_flag(flags[1]), .speed_sync_fault_flag(flags[2]), .cal_compare_flag(flags[3]),
    .spindle_current_sign(flags[4]), .converter_data(conv), .register_image(register_image),
    .protocol_select_bit(protocol_select_bit));
  serial_host_model i_host (.serial_clock(serial_clock), .serial_enable_line(serial_enable_line),
    .serial_io_in(serial_io_in), .serial_io_out(serial_io_out), .serial_io_oe_n(serial_io_oe_n));
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input bit inv, input bit rw, input logic [3:0] a, input logic [7:0] d, input int n,
    input logic [2:0] id);
    i_host.frame(inv, {rw, id, a, d, 1'b0}, n, rd_v, drv);
    repeat (6) @(posedge clock);
  endtask
  task automatic complete_run;
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #60000;
    error_cnt++;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    chk(register_image, 128'h0);
    chk(protocol_select_bit, 1'b0);
    foreach (rows[i]) begin
      xfer(0, 0, rows[i].a, rows[i].w, 16, dev_id);
      model[8 * rows[i].a +: 8] = rows[i].img;
      chk(register_image, model);
      xfer(0, 1, rows[i].a, 8'h00, 16, dev_id);
      chk(rd_v, rows[i].rd);
    end
    // Short, long and foreign frames leave the bank untouched
    xfer(0, 0, 4'h1, 8'hee, 15, dev_id);
    xfer(0, 0, 4'h1, 8'hee, 17, dev_id);
    xfer(0, 0, 4'h1, 8'hee, 16, 3'h2);
    chk(register_image, model);
    xfer(0, 1, 4'h1, 8'h00, 16, 3'h2);
    chk(drv, 1'b0);
    xfer(0, 0, 4'h5, 8'h80, 16, dev_id);
    model[47:40] = 8'h80;
    chk(protocol_select_bit, 1'b1);
    flags <= 5'b01001;
    conv <= 10'h15a;
    xfer(1, 0, 4'he, 8'hc3, 16, dev_id);
    xfer(1, 0, 4'he, 8'h11, 15, dev_id);
    model[119:112] = 8'hc3;
    chk(register_image, model);
    xfer(1, 1, 4'he, 8'h00, 16, dev_id);
    chk(rd_v, 8'hc3);
    xfer(1, 1, 4'h0, 8'h00, 16, dev_id);
    chk(rd_v, 8'h49);
    xfer(1, 1, 4'hb, 8'h00, 16, dev_id);
    chk(rd_v, 8'h56);
    arst_n <= 1'b0;
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    chk(register_image, 128'h0);
    chk(protocol_select_bit, 1'b0);
    complete_run;
  end
endmodule
